// ===== rio_pkg.sv
// Purpose: constants and types of the remote i/o register map
// Assumes: addresses are register numbers as the bus master sees them
// Notes: filter times are in microseconds, clock rate in kHz
package rio_pkg;
  localparam int          NSLOT        = 7;
  localparam int          BASE_IN_BITS = 12;
  localparam logic [11:0] IN_BASE      = 12'h000;
  localparam logic [11:0] IN_LAST      = 12'h063;
  localparam logic [11:0] OUT_BASE     = 12'h064;
  localparam logic [11:0] OUT_LAST     = 12'h0c7;
  localparam logic [11:0] PAR_BASE     = 12'h0c8;
  localparam logic [11:0] PAR_FB_MODE  = 12'h0d4;
  localparam logic [11:0] PAR_FB_VAL   = 12'h0d5;
  localparam logic [11:0] PAR_EXP      = 12'h0d6;
  localparam logic [11:0] PAR_LAST     = 12'h257;
  localparam logic [11:0] FC_BASE      = 12'h258;
  localparam logic [11:0] FC_WORDS     = 12'h008;
  localparam logic [11:0] VFC_BASE     = 12'h2bc;
  localparam logic [11:0] VFC_WORDS    = 12'h00e;
  localparam logic [11:0] PG_BASE      = 12'h320;
  localparam logic [11:0] PG_WORDS     = 12'h00a;
  localparam logic [11:0] FN_STRIDE    = 12'h014;
  localparam logic [11:0] DIAG_BASE    = 12'h384;
  localparam logic [11:0] DIAG_EXP     = 12'h38f;
  localparam logic [11:0] BEH_BASE     = 12'h3e8;
  localparam logic [11:0] BEH_LAST     = 12'h3ed;
  localparam logic [11:0] DEF_BASE     = 12'h4b0;
  localparam logic [11:0] DEF_LAST     = 12'h577;
  localparam logic [11:0] CUS_BASE     = 12'h7d0;
  localparam logic [11:0] CUS_RW       = 12'h834;
  localparam logic [11:0] CUS_LAST     = 12'h897;
  localparam logic [15:0] MFR_END      = 16'h04b0;
  localparam int          DEF_DEPTH    = 200;
  localparam logic [1:0]  FILT_NONE    = 2'h0;
  localparam logic [1:0]  FILT_3MS     = 2'h1;
  localparam logic [1:0]  FILT_12MS    = 2'h2;
  localparam logic [23:0] FILT_RST     = 24'h555555;
  localparam logic [7:0]  FB_MODE_RST  = 8'hff;
  localparam logic [7:0]  FB_VAL_RST   = 8'h00;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_VALUE    = 8'h03;
  localparam int          CLK_KHZ      = 40000;
  localparam int          FILT3_US     = 3000;
  localparam int          FILT12_US    = 12000;
  localparam int          FILT3_CYC_DEF  = (FILT3_US * CLK_KHZ + 999) / 1000;
  localparam int          FILT12_CYC_DEF = (FILT12_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [2:0] {
    MOD_NONE  = 3'h0,
    MOD_IN16  = 3'h1,
    MOD_IN32  = 3'h2,
    MOD_OUT16 = 3'h3,
    MOD_OUT32 = 3'h4,
    MOD_MIX   = 3'h5
  } mod_t;

  typedef struct packed {
    logic [2:0] nin;
    logic [2:0] nout;
    logic [2:0] npar;
  } mod_words_t;

  function automatic mod_words_t words_of(input mod_t t);
    case (t)
      MOD_IN16:  return '{3'h1, 3'h0, 3'h0};
      MOD_IN32:  return '{3'h2, 3'h0, 3'h0};
      MOD_OUT16: return '{3'h0, 3'h1, 3'h2};
      MOD_OUT32: return '{3'h0, 3'h2, 3'h4};
      MOD_MIX:   return '{3'h1, 3'h1, 3'h2};
      default:   return '{3'h0, 3'h0, 3'h0};
    endcase
  endfunction
endpackage

// ===== rio_mem_if.sv
// Purpose: carrier between register map and definition memory
// Assumes: one write and one read port on mclk_i
// Notes: read data appear one enabled edge after the address
`timescale 1ns/1ps
interface rio_mem_if;
  logic        we;
  logic [7:0]  waddr;
  logic [15:0] wdata;
  logic [7:0]  raddr;
  logic [15:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface

// ===== rio_def_mem.sv
// Purpose: definition entries of both custom zones
// Assumes: entries 0..99 read-only zone, 100..199 read/write zone
// Notes: contents are not reset; the master loads them before use
`timescale 1ns/1ps
module rio_def_mem #(
  parameter int DEPTH = 200
)(
  // clock and enable
  input  wire logic mclk_i,
  input  wire logic ce_i,
  // memory port
  rio_mem_if.mem    m
);
  logic [15:0] mem_q [DEPTH];
  logic [15:0] rdata_q;

  always_ff @(posedge mclk_i) begin
    if (ce_i) begin
      if (m.we && int'(m.waddr) < DEPTH) begin
        mem_q[m.waddr] <= m.wdata;
      end
      rdata_q <= (int'(m.raddr) < DEPTH) ? mem_q[m.raddr] : 16'h0000;
    end
  end

  assign m.rdata = rdata_q;
endmodule

// ===== rio_regmap.sv
// Purpose: register space of a remote discrete i/o island
// Assumes: comm_err_i and expansion data are on mclk_i
// Notes: answer comes two enabled edges after a request is taken
`timescale 1ns/1ps
module rio_regmap import rio_pkg::*; #(
  parameter int FILT3_CYC  = FILT3_CYC_DEF,
  parameter int FILT12_CYC = FILT12_CYC_DEF,
  parameter int CW         = 19
)(
  // clock, reset, enable
  input  wire logic                    mclk_i,
  input  wire logic                    srst_i,
  input  wire logic                    ce_i,
  // register request
  input  wire logic                    req_valid_i,
  input  wire logic                    req_write_i,
  input  wire logic [11:0]             req_addr_i,
  input  wire logic [15:0]             req_wdata_i,
  output logic                         req_ready_o,
  // register answer
  output logic                         rsp_valid_o,
  output logic                         rsp_exc_o,
  output logic [7:0]                   rsp_code_o,
  output logic [15:0]                  rsp_data_o,
  // base module pins
  input  wire logic                    comm_err_i,
  input  wire logic [BASE_IN_BITS-1:0] base_in_i,
  output logic [7:0]                   base_out_o,
  // expansion bus
  input  wire logic [NSLOT*3-1:0]      exp_type_i,
  input  wire logic [NSLOT*32-1:0]     exp_in_i,
  output logic [NSLOT*32-1:0]          exp_out_o
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_EXEC = 2'b10
  } fsm_t;

  typedef struct packed {
    fsm_t                       fsm;
    logic                       wr;
    logic [11:0]                addr;
    logic [15:0]                wdata;
    logic                       rv;
    logic                       exc;
    logic [7:0]                 code;
    logic [15:0]                rdata;
    logic [7:0]                 cmd;
    logic [7:0]                 fbm;
    logic [7:0]                 fbv;
    logic [7:0]                 outq;
    logic [2*BASE_IN_BITS-1:0]  filt;
    logic [BASE_IN_BITS-1:0]    s1;
    logic [BASE_IN_BITS-1:0]    s2;
    logic [BASE_IN_BITS-1:0]    flt;
    logic [BASE_IN_BITS*CW-1:0] cnt;
    logic [NSLOT*32-1:0]        xout;
  } st_t;

  st_t         st_q;
  st_t         st_d;
  rio_mem_if   mif ();

  logic [NSLOT*3-1:0] cin;
  logic [NSLOT*3-1:0] cout;
  logic [NSLOT*3-1:0] cpar;
  logic [NSLOT*3-1:0] cdiag;
  logic               cust;
  logic [11:0]        ea;
  logic               bad_ind;
  logic [6:0]         l_in;
  logic [6:0]         l_out;
  logic [6:0]         l_par;
  logic [6:0]         l_dia;

  function automatic logic in_rng(input logic [11:0] a, lo, hi);
    return a >= lo && a <= hi;
  endfunction

  // two instances of a function spaced one stride apart
  function automatic logic twin(input logic [11:0] a, base, words);
    logic [11:0] off;
    off = a - base;
    return off < words || (off >= FN_STRIDE && off < FN_STRIDE + words);
  endfunction

  // finds {hit, slot, word} of an offset in a packed zone
  function automatic logic [6:0] locate(input logic [NSLOT*3-1:0] c,
                                        input logic [11:0] off);
    logic [11:0] acc;
    logic [6:0]  r;
    acc = 12'h000;
    r   = 7'h00;
    for (int k = 0; k < NSLOT; k++) begin
      if (!r[6] && off >= acc && off < acc + 12'(c[k*3 +: 3])) begin
        r = {1'b1, 3'(k), 3'(off - acc)};
      end
      acc = acc + 12'(c[k*3 +: 3]);
    end
    return r;
  endfunction

  // a gap in the chain hides every module to its right
  always_comb begin
    logic       pres;
    mod_words_t w;
    pres = 1'b1;
    w    = '0;
    for (int k = 0; k < NSLOT; k++) begin
      pres = pres && mod_t'(exp_type_i[k*3 +: 3]) != MOD_NONE;
      w = words_of(mod_t'(exp_type_i[k*3 +: 3]));
      cin[k*3 +: 3]   = pres ? w.nin : 3'h0;
      cout[k*3 +: 3]  = pres ? w.nout : 3'h0;
      cpar[k*3 +: 3]  = pres ? w.npar : 3'h0;
      cdiag[k*3 +: 3] = pres ? 3'h1 : 3'h0;
    end
  end

  assign cust    = in_rng(st_q.addr, CUS_BASE, CUS_LAST);
  assign ea      = cust ? mif.rdata[11:0] : st_q.addr;
  // custom entries may only name manufacturer registers
  assign bad_ind = cust && (mif.rdata >= MFR_END ||
                   (st_q.wr && st_q.addr < CUS_RW));
  assign l_in    = locate(cin, ea - IN_BASE - 12'h001);
  assign l_out   = locate(cout, ea - OUT_BASE - 12'h001);
  assign l_par   = locate(cpar, ea - PAR_EXP);
  assign l_dia   = locate(cdiag, ea - DIAG_EXP);

  always_comb begin
    logic [CW-1:0] c;
    logic [CW-1:0] lim;
    logic          ok;
    logic          ro;
    logic [15:0]   rd;
    logic [1:0]    fs;
    int            fi;
    c   = '0;
    lim = '0;
    ok  = 1'b0;
    ro  = 1'b0;
    rd  = 16'h0000;
    fs  = FILT_NONE;
    fi  = 0;
    st_d = st_q;
    st_d.rv = 1'b0;
    mif.we    = 1'b0;
    mif.waddr = 8'(st_q.addr - DEF_BASE);
    mif.wdata = st_q.wdata;
    mif.raddr = in_rng(req_addr_i, CUS_BASE, CUS_LAST) ?
                8'(req_addr_i - CUS_BASE) : 8'(req_addr_i - DEF_BASE);

    st_d.s1 = base_in_i;
    st_d.s2 = st_q.s1;
    for (int i = 0; i < BASE_IN_BITS; i++) begin
      c  = st_q.cnt[i*CW +: CW];
      fs = st_q.filt[i*2 +: 2];
      lim = (fs == FILT_12MS) ? CW'(FILT12_CYC - 1) : CW'(FILT3_CYC - 1);
      if (fs == FILT_NONE || fs > FILT_12MS) begin
        st_d.flt[i] = st_q.s2[i];
        c = '0;
      end else if (st_q.s2[i] == st_q.flt[i]) begin
        c = '0;
      end else if (c >= lim) begin
        st_d.flt[i] = st_q.s2[i];
        c = '0;
      end else begin
        c = c + CW'(1);
      end
      st_d.cnt[i*CW +: CW] = c;
    end

    // hold mode keeps what the pins last showed
    st_d.outq = comm_err_i ?
                ((st_q.fbm & st_q.fbv) | (~st_q.fbm & st_q.outq)) :
                st_q.cmd;

    case (st_q.fsm)
      S_IDLE: begin
        if (req_valid_i) begin
          st_d.fsm   = S_EXEC;
          st_d.wr    = req_write_i;
          st_d.addr  = req_addr_i;
          st_d.wdata = req_wdata_i;
        end
      end
      S_EXEC: begin
        st_d.fsm = S_IDLE;
        st_d.rv  = 1'b1;
        if (!cust && in_rng(ea, DEF_BASE, DEF_LAST)) begin
          ok = 1'b1;
          rd = mif.rdata;
        end else if (ea == IN_BASE) begin
          ok = 1'b1;
          ro = 1'b1;
          rd = {4'h0, st_q.flt};
        end else if (in_rng(ea, IN_BASE, IN_LAST)) begin
          ok = l_in[6];
          ro = 1'b1;
          rd = exp_in_i[int'(l_in[5:3])*32 + int'(l_in[2:0])*16 +: 16];
        end else if (ea == OUT_BASE) begin
          ok = 1'b1;
          rd = {8'h00, st_q.cmd};
        end else if (in_rng(ea, OUT_BASE, OUT_LAST)) begin
          ok = l_out[6];
          rd = st_q.xout[int'(l_out[5:3])*32 + int'(l_out[2:0])*16 +: 16];
        end else if (ea < PAR_FB_MODE && ea >= PAR_BASE) begin
          ok = 1'b1;
          fi = int'(ea - PAR_BASE);
          rd = {14'h0000, st_q.filt[fi*2 +: 2]};
        end else if (ea == PAR_FB_MODE) begin
          ok = 1'b1;
          rd = {8'h00, st_q.fbm};
        end else if (ea == PAR_FB_VAL) begin
          ok = 1'b1;
          rd = {8'h00, st_q.fbv};
        end else if (in_rng(ea, PAR_EXP, PAR_LAST)) begin
          ok = l_par[6];
        end else if (twin(ea, FC_BASE, FC_WORDS) ||
                     twin(ea, VFC_BASE, VFC_WORDS) ||
                     twin(ea, PG_BASE, PG_WORDS) ||
                     in_rng(ea, BEH_BASE, BEH_LAST)) begin
          ok = 1'b1;
        end else if (in_rng(ea, DIAG_BASE, DIAG_EXP - 12'h001)) begin
          ok = 1'b1;
          ro = 1'b1;
        end else if (ea >= DIAG_EXP) begin
          ok = l_dia[6] && ea < BEH_BASE;
          ro = 1'b1;
        end
        ok = ok && !bad_ind;
        st_d.rdata = st_q.wr ? 16'h0000 : rd;
        st_d.exc   = 1'b0;
        st_d.code  = 8'h00;
        if (!ok || (st_q.wr && ro)) begin
          st_d.exc   = 1'b1;
          st_d.code  = EXC_ADDR;
          st_d.rdata = 16'h0000;
        end else if (st_q.wr) begin
          if (!cust && in_rng(ea, DEF_BASE, DEF_LAST)) begin
            mif.we = 1'b1;
          end else if (ea == OUT_BASE) begin
            st_d.cmd = st_q.wdata[7:0];
          end else if (in_rng(ea, OUT_BASE, OUT_LAST)) begin
            st_d.xout[int'(l_out[5:3])*32 + int'(l_out[2:0])*16 +: 16] =
              st_q.wdata;
          end else if (ea < PAR_FB_MODE && ea >= PAR_BASE) begin
            if (st_q.wdata > 16'(FILT_12MS)) begin
              st_d.exc  = 1'b1;
              st_d.code = EXC_VALUE;
            end else begin
              st_d.filt[fi*2 +: 2] = st_q.wdata[1:0];
            end
          end else if (ea == PAR_FB_MODE) begin
            st_d.fbm = st_q.wdata[7:0];
          end else if (ea == PAR_FB_VAL) begin
            st_d.fbv = st_q.wdata[7:0];
          end
        end
      end
      default: st_d.fsm = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q      <= '0;
      st_q.fsm  <= S_IDLE;
      st_q.fbm  <= FB_MODE_RST;
      st_q.fbv  <= FB_VAL_RST;
      st_q.filt <= FILT_RST;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  rio_def_mem #(
    .DEPTH (DEF_DEPTH)
  ) u_def (
    .mclk_i (mclk_i),
    .ce_i   (ce_i),
    .m      (mif.mem)
  );

  assign req_ready_o = st_q.fsm == S_IDLE;
  assign rsp_valid_o = st_q.rv;
  assign rsp_exc_o   = st_q.exc;
  assign rsp_code_o  = st_q.code;
  assign rsp_data_o  = st_q.rdata;
  assign base_out_o  = st_q.outq;
  assign exp_out_o   = st_q.xout;

  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (srst_i || !ce_i);

  wire exec = st_q.fsm == S_EXEC;

  a_answer_time: assert property (req_valid_i && req_ready_o |=> ##1
    rsp_valid_o) else $error("answer not two cycles after request");
  a_absent_refused: assert property (exec && in_rng(ea, 12'h001, IN_LAST)
    && !l_in[6] |=> rsp_exc_o && rsp_code_o == EXC_ADDR)
    else $error("absent input word not refused");
  a_word0_pack: assert property (exec && ea == IN_BASE && !st_q.wr
    && !bad_ind |=> rsp_data_o == {4'h0, $past(st_q.flt)})
    else $error("status word 0 wrong");
  a_cust_read: assert property (exec && cust && !st_q.wr && ea == 12'h000
    && !bad_ind |=> !rsp_exc_o && rsp_data_o[15:12] == 4'h0)
    else $error("custom read of word 0 wrong");
  a_cust_write: assert property (exec && cust && st_q.wr && !bad_ind
    && ea == OUT_BASE |=> st_q.cmd == $past(st_q.wdata[7:0]))
    else $error("custom write did not reach command word");
  a_fallback_out: assert property (comm_err_i |=> base_out_o ==
    (($past(st_q.fbm) & $past(st_q.fbv)) |
     (~$past(st_q.fbm) & $past(base_out_o))))
    else $error("fallback output wrong");
  a_hold_mode: assert property (comm_err_i && st_q.fbm == 8'h00
    |=> $stable(base_out_o)) else $error("hold mode changed outputs");
  a_filter_none: assert property (st_q.filt[1:0] == FILT_NONE
    |=> st_q.flt[0] == $past(st_q.s2[0]))
    else $error("unfiltered input lagged");
  a_exp_unfilt: assert property (exec && !st_q.wr && !bad_ind && l_in[6]
    && in_rng(ea, 12'h001, IN_LAST) |=> rsp_data_o == $past(exp_in_i[15:0])
    || $past(l_in[5:0]) != 6'h00) else $error("expansion input altered");
  a_diag_base: assert property (exec && ea == DIAG_EXP - 12'h001
    && !bad_ind && !st_q.wr |=> !rsp_exc_o)
    else $error("base diagnostic word refused");
  a_first_slot: assert property (exec && ea == 12'h001 && cin[2:0] != 0
    |-> l_in[6] && l_in[5:3] == 3'h0) else $error("first window misplaced");

  c_cust_read: cover property (exec && cust && !st_q.wr ##1 rsp_valid_o);
  c_cust_write: cover property (exec && cust && st_q.wr ##1 !rsp_exc_o);
  c_refused: cover property (rsp_valid_o && rsp_exc_o);
  c_fallback: cover property (comm_err_i ##1 base_out_o != st_q.cmd);
endmodule

// ===== rio_master.sv
// Purpose: bus master model issuing register requests to the island
// Assumes: requests start right after a rising edge of mclk_i
// Notes: released request lines show inverted data, never the old value
`timescale 1ns/1ps
module rio_master (
  // clock
  input  wire logic        mclk_i,
  // request
  output logic             req_valid_o,
  output logic             req_write_o,
  output logic [11:0]      req_addr_o,
  output logic [15:0]      req_wdata_o,
  input  wire logic        req_ready_i,
  // answer
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_exc_i,
  input  wire logic [7:0]  rsp_code_i,
  input  wire logic [15:0] rsp_data_i
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_addr_o  = 12'h000;
    req_wdata_o = 16'h0000;
  end

  // ans is {exception, code, data}; lat counts edges after the taking one
  task automatic access(input  logic        wr,
                        input  logic [11:0] addr,
                        input  logic [15:0] wdata,
                        output logic [24:0] ans,
                        output int          lat);
    req_valid_o <= 1'b1;
    req_write_o <= wr;
    req_addr_o  <= addr;
    req_wdata_o <= wdata;
    do @(posedge mclk_i); while (req_ready_i !== 1'b1);
    req_valid_o <= 1'b0;
    req_write_o <= ~wr;
    req_addr_o  <= ~addr;
    req_wdata_o <= ~wdata;
    lat = 0;
    do begin
      @(posedge mclk_i);
      lat++;
    end while (rsp_valid_i !== 1'b1 && lat < 8);
    ans = {rsp_exc_i, rsp_code_i, rsp_data_i};
  endtask
endmodule

// ===== remote_io_register_map_bench.sv
// Purpose: self-checking bench of the remote i/o register map
// Assumes: clock enable dropped once while idle; short filter counts
// Notes: slots in16, mixed, out32, in32, empty, then in16, out16 cut off
`timescale 1ns/1ps
module remote_io_register_map_bench import rio_pkg::*;
  ;
  localparam int          F3  = 8;
  localparam int          F12 = 24;
  localparam logic [24:0] OK0 = 25'h0000000;
  localparam logic [24:0] E2  = {1'b1, EXC_ADDR, 16'h0000};
  localparam logic [24:0] E3  = {1'b1, EXC_VALUE, 16'h0000};

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [15:0] wd;
    logic [24:0] exp;
  } row_t;

  logic            mclk;
  logic            srst;
  logic            ce;
  logic            req_valid;
  logic            req_write;
  logic [11:0]     req_addr;
  logic [15:0]     req_wdata;
  logic            req_ready;
  logic            rsp_valid;
  logic            rsp_exc;
  logic [7:0]      rsp_code;
  logic [15:0]     rsp_data;
  logic            comm_err;
  logic [11:0]     base_in;
  logic [7:0]      base_out;
  logic [20:0]     exp_type;
  logic [223:0]    exp_in;
  logic [223:0]    exp_out;
  row_t            rows[$];
  int              fails;
  int              n_tests;

  rio_regmap #(.FILT3_CYC(F3), .FILT12_CYC(F12)) u_dut (
    .mclk_i(mclk), .srst_i(srst), .ce_i(ce),
    .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
    .rsp_exc_o(rsp_exc), .rsp_code_o(rsp_code), .rsp_data_o(rsp_data),
    .comm_err_i(comm_err), .base_in_i(base_in), .base_out_o(base_out),
    .exp_type_i(exp_type), .exp_in_i(exp_in), .exp_out_o(exp_out)
  );

  rio_master u_master (
    .mclk_i(mclk), .req_valid_o(req_valid), .req_write_o(req_write),
    .req_addr_o(req_addr), .req_wdata_o(req_wdata),
    .req_ready_i(req_ready), .rsp_valid_i(rsp_valid),
    .rsp_exc_i(rsp_exc), .rsp_code_i(rsp_code), .rsp_data_i(rsp_data)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [24:0] ok(input logic [15:0] d);
    return {9'h000, d};
  endfunction

  task automatic rd(input logic [11:0] a, input logic [24:0] e);
    rows.push_back({1'b0, a, 16'h0000, e});
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [24:0] e);
    rows.push_back({1'b1, a, d, e});
  endtask

  // code is only meaningful with an exception; latency must be two
  task automatic xfer(input row_t r);
    logic [24:0] ans;
    int          lat;
    u_master.access(r.wr, r.addr, r.wd, ans, lat);
    if (ans[24] !== 1'b1) ans[23:16] = 8'h00;
    check({lat[6:0], ans}, {7'h02, r.exp});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    end_of_test();
  end

  initial begin
    srst     = 1'b1;
    ce       = 1'b1;
    comm_err = 1'b0;
    base_in  = 12'ha5c;
    exp_type = {MOD_OUT16, MOD_IN16, MOD_NONE, MOD_IN32, MOD_OUT32,
                MOD_MIX, MOD_IN16};
    exp_in          = '0;
    exp_in[15:0]    = 16'h1111;
    exp_in[47:32]   = 16'h2222;
    exp_in[111:96]  = 16'h3333;
    exp_in[127:112] = 16'h4444;
    exp_in[175:160] = 16'h5555;
    rd(12'h001, ok(16'h1111));
    rd(12'h002, ok(16'h2222));
    rd(12'h003, ok(16'h3333));
    rd(12'h004, ok(16'h4444));
    rd(12'h005, E2);
    wr(12'h065, 16'ha5a5, OK0);
    rd(12'h065, ok(16'ha5a5));
    wr(12'h066, 16'h1234, OK0);
    wr(12'h067, 16'h5678, OK0);
    wr(12'h068, 16'h0001, E2);
    wr(12'h001, 16'h0001, E2);
    rd(12'h0d7, OK0);
    rd(12'h0db, OK0);
    rd(12'h0dc, E2);
    rd(12'h38e, OK0);
    rd(12'h38f, OK0);
    rd(12'h392, OK0);
    rd(12'h393, E2);
    rd(12'h25f, OK0);
    rd(12'h260, E2);
    rd(12'h273, OK0);
    rd(12'h2c9, OK0);
    rd(12'h2ca, E2);
    rd(12'h2dd, OK0);
    rd(12'h329, OK0);
    rd(12'h32a, E2);
    rd(12'h33d, OK0);
    rd(12'h3ed, OK0);
    rd(12'h3ee, E2);
    rd(12'h0c8, ok(16'h0001));
    wr(12'h0c8, 16'h0003, E3);
    rd(12'h0c8, ok(16'h0001));
    rd(12'h0d3, ok(16'h0001));
    rd(12'h0d4, ok(16'h00ff));
    rd(12'h0d5, OK0);
    rd(12'h000, ok(16'h0a5c));
    wr(12'h4b0, 16'h0000, OK0);
    wr(12'h4b1, 16'h0003, OK0);
    wr(12'h514, 16'h0064, OK0);
    rd(12'h7d0, ok(16'h0a5c));
    rd(12'h7d1, ok(16'h3333));
    wr(12'h834, 16'h00c3, OK0);
    rd(12'h064, ok(16'h00c3));
    rd(12'h834, ok(16'h00c3));
    wr(12'h7d0, 16'h0001, E2);
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) xfer(rows[i]);
    check({16'h0, exp_out[47:32]}, 32'h0000a5a5);
    check(exp_out[95:64], 32'h56781234);
    // filters: input 0 none, 1 long, 2 short
    xfer({1'b1, 12'h0c8, 16'h0000, OK0});
    xfer({1'b1, 12'h0c9, 16'h0002, OK0});
    base_in <= base_in ^ 12'h007;
    exp_in[15:0] <= 16'heeee;
    xfer({1'b0, 12'h001, 16'h0000, ok(16'heeee)});
    xfer({1'b0, 12'h000, 16'h0000, ok(16'h0a5d)});
    repeat (10) @(posedge mclk);
    xfer({1'b0, 12'h000, 16'h0000, ok(16'h0a59)});
    repeat (25) @(posedge mclk);
    xfer({1'b0, 12'h000, 16'h0000, ok(16'h0a5b)});
    // fallback: default forces 0, then mixed hold and value
    check({24'h0, base_out}, 32'h000000c3);
    // enable low freezes the outputs even on an error
    ce       <= 1'b0;
    comm_err <= 1'b1;
    repeat (3) @(posedge mclk);
    check({24'h0, base_out}, 32'h000000c3);
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
    check({24'h0, base_out}, 32'h00000000);
    comm_err <= 1'b0;
    repeat (3) @(posedge mclk);
    check({24'h0, base_out}, 32'h000000c3);
    xfer({1'b1, 12'h0d4, 16'h000f, OK0});
    xfer({1'b1, 12'h0d5, 16'h005a, OK0});
    comm_err <= 1'b1;
    repeat (3) @(posedge mclk);
    check({24'h0, base_out}, 32'h000000ca);
    // hold on every output: the stored value byte must be ignored
    xfer({1'b1, 12'h0d4, 16'h0000, OK0});
    repeat (2) @(posedge mclk);
    check({24'h0, base_out}, 32'h000000ca);
    // second reset in mid-run
    comm_err <= 1'b0;
    srst     <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check({24'h0, base_out}, 32'h00000000);
    check(exp_out[95:64], 32'h00000000);
    xfer({1'b0, 12'h0c9, 16'h0000, ok(16'h0001)});
    xfer({1'b0, 12'h0d4, 16'h0000, ok(16'h00ff)});
    xfer({1'b0, 12'h064, 16'h0000, OK0});
    end_of_test();
  end
endmodule
